/* File: ild_fmt_if.sv */
// Interface between the load sequencer and the load data formatter.
`timescale 1ns/1ps
interface ild_fmt_if;
  logic [ild_pkg::XLEN-1:0] word0;
  logic [ild_pkg::XLEN-1:0] word1;
  logic [ild_pkg::OFFS_W-1:0] offset;
  logic [1:0] size;
  logic signExt;
  logic [ild_pkg::XLEN-1:0] result;

  // The sequencer supplies memory words and operand shape.
  modport seq (output word0, output word1, output offset, output size, output signExt,
               input result);
  // The formatter returns the aligned, extended operand.
  modport fmt (input word0, input word1, input offset, input size, input signExt,
               output result);
endinterface

/* File: ild_format.sv */
// Load data formatter: big-endian byte extraction with zero or sign extension.
`timescale 1ns/1ps
module ild_format (
  // Operands and result.
  ild_fmt_if.fmt bus
);

  logic [2*ild_pkg::XLEN-1:0] pair;
  logic [2*ild_pkg::XLEN-1:0] shifted;
  logic [ild_pkg::XLEN-1:0] top;

  // Join both words and move the addressed byte to the most significant lane.
  always_comb begin
    pair = {bus.word0, bus.word1};
    shifted = pair << {bus.offset, 3'h0};
    top = shifted[2*ild_pkg::XLEN-1:ild_pkg::XLEN];
  end

  // Place the operand in the low bits and fill the rest by the load type.
  always_comb begin
    if (bus.size == ild_pkg::ILD_SIZE_BYTE) begin
      if (bus.signExt) begin
        bus.result = {{(ild_pkg::XLEN-ild_pkg::BYTE_W){top[ild_pkg::XLEN-1]}},
                      top[ild_pkg::XLEN-1 -: ild_pkg::BYTE_W]};
      end else begin
        bus.result = {{(ild_pkg::XLEN-ild_pkg::BYTE_W){1'b0}},
                      top[ild_pkg::XLEN-1 -: ild_pkg::BYTE_W]};
      end
    end else if (bus.size == ild_pkg::ILD_SIZE_HALF) begin
      if (bus.signExt) begin
        bus.result = {{(ild_pkg::XLEN-ild_pkg::HALF_W){top[ild_pkg::XLEN-1]}},
                      top[ild_pkg::XLEN-1 -: ild_pkg::HALF_W]};
      end else begin
        bus.result = {{(ild_pkg::XLEN-ild_pkg::HALF_W){1'b0}},
                      top[ild_pkg::XLEN-1 -: ild_pkg::HALF_W]};
      end
    end else begin
      bus.result = top;
    end
  end

endmodule

/* File: ild_load_unit.sv */
// Integer load unit: effective address, memory access and result formatting.
//
// Behaviour
// - Immediate mode: base plus sign-extended displacement.
// - Index mode: base plus index register.
// - Non-update base field zero uses zero.
// - Register-indirect mode only for string transfers.
// - Register-indirect with field zero gives zero.
// - Update forms write address to base register.
// - Four forms per load type supported.
// - Zero-extending narrow loads clear upper bits.
// - Sign-extending loads copy operand top bit.
// - Byte load zero-fills upper 24 bits.
// - Halfword load zero-fills upper 16 bits.
// - Algebraic halfword copies sign into upper half.
// - Word load moves whole 32-bit word.
// - Invalid update forms complete without exception.
// - Memory accesses may be reordered without sync.
// - Unaligned loads complete; those crossing a word use extra cycles.
`timescale 1ns/1ps
module ild_load_unit (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Load request from instruction decode.
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [1:0] reqMode,
  input wire logic reqUpdate,
  input wire logic reqString,
  input wire logic [1:0] reqSize,
  input wire logic reqSignExt,
  input wire logic [ild_pkg::REG_FIELD_W-1:0] reqBaseField,
  input wire logic [ild_pkg::REG_FIELD_W-1:0] reqDestField,
  input wire logic [ild_pkg::XLEN-1:0] reqBaseValue,
  input wire logic [ild_pkg::XLEN-1:0] reqIndexValue,
  input wire logic [ild_pkg::DISP_W-1:0] reqDisp,
  output logic reqRejected,
  // Data memory port, word addressed.
  output logic memReqValid,
  output logic [ild_pkg::XLEN-1:0] memAddr,
  input wire logic memAck,
  input wire logic [ild_pkg::XLEN-1:0] memRdata,
  // Register file write-back.
  output logic wbValid,
  output logic [ild_pkg::REG_FIELD_W-1:0] wbDestField,
  output logic [ild_pkg::XLEN-1:0] wbDestData,
  output logic wbBaseValid,
  output logic [ild_pkg::REG_FIELD_W-1:0] wbBaseField,
  output logic [ild_pkg::XLEN-1:0] wbBaseData
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    ild_pkg::ild_state_t state;
    logic reqReady;
    logic reqRejected;
    logic memReqValid;
    logic [ild_pkg::XLEN-1:0] memAddr;
    logic [ild_pkg::XLEN-1:0] ea;
    logic [ild_pkg::XLEN-1:0] word0;
    logic [1:0] size;
    logic signExt;
    logic update;
    logic wbValid;
    logic [ild_pkg::REG_FIELD_W-1:0] wbDestField;
    logic [ild_pkg::XLEN-1:0] wbDestData;
    logic wbBaseValid;
    logic [ild_pkg::REG_FIELD_W-1:0] wbBaseField;
    logic [ild_pkg::XLEN-1:0] wbBaseData;
  } ild_unit_state_t;

  localparam ild_unit_state_t RESET_STATE = '{
    state: ild_pkg::ILD_ST_IDLE,
    reqReady: 1'b1,
    reqRejected: 1'b0,
    memReqValid: 1'b0,
    memAddr: ild_pkg::ZERO_WORD,
    ea: ild_pkg::ZERO_WORD,
    word0: ild_pkg::ZERO_WORD,
    size: ild_pkg::ILD_SIZE_WORD,
    signExt: 1'b0,
    update: 1'b0,
    wbValid: 1'b0,
    wbDestField: ild_pkg::ZERO_FIELD,
    wbDestData: ild_pkg::ZERO_WORD,
    wbBaseValid: 1'b0,
    wbBaseField: ild_pkg::ZERO_FIELD,
    wbBaseData: ild_pkg::ZERO_WORD
  };

  ild_unit_state_t stateReg;
  ild_unit_state_t stateNext;

  logic accept;
  logic badMode;
  logic [ild_pkg::XLEN-1:0] baseOperand;
  logic [ild_pkg::XLEN-1:0] dispExt;
  logic [ild_pkg::XLEN-1:0] offsetOperand;
  logic [ild_pkg::XLEN-1:0] eaCalc;
  logic crossing;
  logic finish;

  ild_fmt_if fmtBus ();

  // ----------------------------------------------------------------------
  // Address generation
  // ----------------------------------------------------------------------
  // Select the base and offset operands and sum them.
  always_comb begin
    accept = reqValid && stateReg.reqReady;
    badMode = (reqMode == ild_pkg::ILD_MODE_IND && !reqString) ||
              (reqMode != ild_pkg::ILD_MODE_IMM && reqMode != ild_pkg::ILD_MODE_IDX &&
               reqMode != ild_pkg::ILD_MODE_IND);
    // Update forms always read the base; an invalid zero field is not trapped.
    if (reqUpdate && reqMode != ild_pkg::ILD_MODE_IND) begin
      baseOperand = reqBaseValue;
    end else if (reqBaseField == ild_pkg::ZERO_FIELD) begin
      baseOperand = ild_pkg::ZERO_WORD;
    end else begin
      baseOperand = reqBaseValue;
    end
    dispExt = {{(ild_pkg::XLEN-ild_pkg::DISP_W){reqDisp[ild_pkg::DISP_W-1]}}, reqDisp};
    if (reqMode == ild_pkg::ILD_MODE_IMM) begin
      offsetOperand = dispExt;
    end else if (reqMode == ild_pkg::ILD_MODE_IDX) begin
      offsetOperand = reqIndexValue;
    end else begin
      offsetOperand = ild_pkg::ZERO_WORD;
    end
    eaCalc = baseOperand + offsetOperand;
  end

  // An operand that spills past its first word needs a second access.
  always_comb begin
    crossing = ({1'b0, stateReg.ea[ild_pkg::OFFS_W-1:0]} + ild_pkg::ild_size_bytes(stateReg.size))
               > ild_pkg::BYTES_IN_WORD;
  end

  // ----------------------------------------------------------------------
  // Data formatting
  // ----------------------------------------------------------------------
  // Feed the formatter with the held first word once a second word is fetched.
  assign fmtBus.word0 = (stateReg.state == ild_pkg::ILD_ST_SECOND) ? stateReg.word0 : memRdata;
  assign fmtBus.word1 = memRdata;
  assign fmtBus.offset = stateReg.ea[ild_pkg::OFFS_W-1:0];
  assign fmtBus.size = stateReg.size;
  assign fmtBus.signExt = stateReg.signExt;

  ild_format uFormat (
    .bus(fmtBus.fmt)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // One load at a time, so memory order follows issue order here.
  always_comb begin
    stateNext = stateReg;
    stateNext.wbValid = 1'b0;
    stateNext.wbBaseValid = 1'b0;
    stateNext.reqRejected = 1'b0;
    finish = 1'b0;
    case (stateReg.state)
      ild_pkg::ILD_ST_IDLE: begin
        if (accept && badMode) begin
          stateNext.reqRejected = 1'b1;
        end else if (accept) begin
          stateNext.ea = eaCalc;
          stateNext.size = reqSize;
          stateNext.signExt = reqSignExt;
          stateNext.update = reqUpdate && reqMode != ild_pkg::ILD_MODE_IND;
          stateNext.wbDestField = reqDestField;
          stateNext.wbBaseField = reqBaseField;
          stateNext.reqReady = 1'b0;
          stateNext.memReqValid = 1'b1;
          stateNext.memAddr = eaCalc & ild_pkg::ALIGN_MASK;
          stateNext.state = ild_pkg::ILD_ST_FIRST;
        end
      end
      ild_pkg::ILD_ST_FIRST: begin
        if (memAck && crossing) begin
          stateNext.word0 = memRdata;
          stateNext.memAddr = stateReg.memAddr + ild_pkg::WORD_STEP;
          stateNext.state = ild_pkg::ILD_ST_SECOND;
        end else if (memAck) begin
          finish = 1'b1;
        end
      end
      ild_pkg::ILD_ST_SECOND: begin
        if (memAck) begin
          finish = 1'b1;
        end
      end
      default: begin
        stateNext = RESET_STATE;
      end
    endcase
    // Both register writes leave in the same cycle.
    if (finish) begin
      stateNext.memReqValid = 1'b0;
      stateNext.wbValid = 1'b1;
      stateNext.wbDestData = fmtBus.result;
      stateNext.wbBaseValid = stateReg.update;
      stateNext.wbBaseData = stateReg.ea;
      stateNext.reqReady = 1'b1;
      stateNext.state = ild_pkg::ILD_ST_IDLE;
    end
  end

  // Register the whole state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= RESET_STATE;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Outputs come straight from the state register.
  assign reqReady = stateReg.reqReady;
  assign reqRejected = stateReg.reqRejected;
  assign memReqValid = stateReg.memReqValid;
  assign memAddr = stateReg.memAddr;
  assign wbValid = stateReg.wbValid;
  assign wbDestField = stateReg.wbDestField;
  assign wbDestData = stateReg.wbDestData;
  assign wbBaseValid = stateReg.wbBaseValid;
  assign wbBaseField = stateReg.wbBaseField;
  assign wbBaseData = stateReg.wbBaseData;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Immediate mode sums the base and the sign-extended displacement.
  property p_imm_ea;
    accept && !badMode && reqMode == ild_pkg::ILD_MODE_IMM && reqBaseField != ild_pkg::ZERO_FIELD
    |=> stateReg.ea == $past(reqBaseValue) +
        {{(ild_pkg::XLEN-ild_pkg::DISP_W){$past(reqDisp[ild_pkg::DISP_W-1])}}, $past(reqDisp)};
  endproperty
  a_imm_ea: assert property (p_imm_ea) else $error("immediate address wrong");

  // Index mode sums base and index.
  property p_idx_ea;
    accept && reqMode == ild_pkg::ILD_MODE_IDX && reqBaseField != ild_pkg::ZERO_FIELD
    |=> stateReg.ea == $past(reqBaseValue) + $past(reqIndexValue);
  endproperty
  a_idx_ea: assert property (p_idx_ea) else $error("indexed address wrong");

  // Non-update forms with a zero base field ignore the base value.
  property p_zero_base;
    accept && !reqUpdate && reqBaseField == ild_pkg::ZERO_FIELD && reqMode == ild_pkg::ILD_MODE_IDX
    |=> stateReg.ea == $past(reqIndexValue);
  endproperty
  a_zero_base: assert property (p_zero_base) else $error("zero base not honoured");

  // Indirect mode without a string transfer is turned away.
  property p_ind_reject;
    accept && reqMode == ild_pkg::ILD_MODE_IND && !reqString
    |=> reqRejected && !memReqValid && reqReady;
  endproperty
  a_ind_reject: assert property (p_ind_reject) else $error("indirect load not rejected");

  // Indirect mode with a zero field reads address zero.
  property p_ind_zero;
    accept && reqMode == ild_pkg::ILD_MODE_IND && reqString && reqBaseField == ild_pkg::ZERO_FIELD
    |=> memReqValid && memAddr == ild_pkg::ZERO_WORD;
  endproperty
  a_ind_zero: assert property (p_ind_zero) else $error("indirect zero address wrong");

  // The base write carries the address the load used, with the data write.
  property p_base_wb;
    wbBaseValid |-> wbValid && wbBaseData == stateReg.ea && wbBaseField == $past(wbBaseField);
  endproperty
  a_base_wb: assert property (p_base_wb) else $error("base write-back wrong");

  // Zero-extended byte loads leave the upper bits clear.
  property p_byte_zero;
    wbValid && stateReg.size == ild_pkg::ILD_SIZE_BYTE && !stateReg.signExt
    |-> wbDestData[ild_pkg::XLEN-1:ild_pkg::BYTE_W] == '0;
  endproperty
  a_byte_zero: assert property (p_byte_zero) else $error("byte not zero extended");

  // Algebraic halfword loads replicate the operand sign.
  property p_half_sign;
    wbValid && stateReg.size == ild_pkg::ILD_SIZE_HALF && stateReg.signExt
    |-> wbDestData[ild_pkg::XLEN-1:ild_pkg::HALF_W] ==
        {(ild_pkg::XLEN-ild_pkg::HALF_W){wbDestData[ild_pkg::HALF_W-1]}};
  endproperty
  a_half_sign: assert property (p_half_sign) else $error("halfword not sign extended");

  // An aligned word load returns the memory word unchanged.
  property p_word;
    stateReg.state == ild_pkg::ILD_ST_FIRST && memAck && !crossing &&
    stateReg.size == ild_pkg::ILD_SIZE_WORD |=> wbValid && wbDestData == $past(memRdata);
  endproperty
  a_word: assert property (p_word) else $error("word load data wrong");

  // A spilling load next requests the following word, with no write-back yet.
  sequence s_first_split;
    stateReg.state == ild_pkg::ILD_ST_FIRST && memAck && crossing;
  endsequence
  sequence s_second_issue;
    memReqValid && !wbValid && memAddr == $past(memAddr) + ild_pkg::WORD_STEP;
  endsequence
  property p_unaligned;
    s_first_split |=> s_second_issue;
  endproperty
  a_unaligned: assert property (p_unaligned) else $error("second word not fetched");

endmodule

/* File: ild_mem_model.sv */
// Behavioural data memory that answers word reads promptly or after wait states.
`timescale 1ns/1ps
module ild_mem_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Latency control: low answers at once, high adds random wait states.
  input wire logic slowMode,
  // Word read port.
  input wire logic memReqValid,
  input wire logic [31:0] memAddr,
  output logic memAck,
  output logic [31:0] memRdata
);
  logic [15:0] lfsrReg;
  logic [1:0] waitReg;

  // Stored word at an address: a fixed scramble of the word address.
  function automatic logic [31:0] wordAt(input logic [31:0] a);
    return {a[31:2], 2'h0} * 32'h9E37_79B9 ^ 32'hC3A5_5A3C;
  endfunction

  // Answers change at the falling edge; between answers the data lines toggle so stale
  // data never looks valid.
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memAck <= 1'b0;
      memRdata <= 32'h0000_0000;
      waitReg <= 2'h0;
      lfsrReg <= 16'h1D3B;
    end else begin
      lfsrReg <= {lfsrReg[14:0], lfsrReg[15] ^ lfsrReg[13] ^ lfsrReg[12] ^ lfsrReg[10]};
      if (memReqValid && waitReg == 2'h0) begin
        memAck <= 1'b1;
        memRdata <= wordAt(memAddr);
        waitReg <= slowMode ? lfsrReg[1:0] : 2'h0;
      end else begin
        memAck <= 1'b0;
        memRdata <= ~memRdata;
        if (memReqValid) begin
          waitReg <= waitReg - 2'h1;
        end
      end
    end
  end
endmodule

/* File: ild_pkg.sv */
// Shared constants, types and helpers for the integer load address and format block.
package ild_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int XLEN = 32;
  localparam int REG_FIELD_W = 5;
  localparam int DISP_W = 16;
  localparam int BYTE_W = 8;
  localparam int HALF_W = 16;
  localparam int OFFS_W = 2;

  // ----------------------------------------------------------------------
  // Constant values
  // ----------------------------------------------------------------------
  localparam logic [REG_FIELD_W-1:0] ZERO_FIELD = 5'h00;
  localparam logic [XLEN-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [XLEN-1:0] WORD_STEP = 32'h0000_0004;
  localparam logic [XLEN-1:0] ALIGN_MASK = 32'hFFFF_FFFC;
  localparam logic [2:0] BYTES_IN_WORD = 3'h4;
  localparam logic [2:0] BYTES_BYTE = 3'h1;
  localparam logic [2:0] BYTES_HALF = 3'h2;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  // Addressing mode as presented by instruction decode.
  typedef enum logic [1:0] {
    ILD_MODE_IMM = 2'h0,
    ILD_MODE_IDX = 2'h1,
    ILD_MODE_IND = 2'h2
  } ild_mode_t;

  // Operand size of the load.
  typedef enum logic [1:0] {
    ILD_SIZE_BYTE = 2'h0,
    ILD_SIZE_HALF = 2'h1,
    ILD_SIZE_WORD = 2'h2
  } ild_size_t;

  // Load sequencer states, one-hot.
  typedef enum logic [2:0] {
    ILD_ST_IDLE = 3'b001,
    ILD_ST_FIRST = 3'b010,
    ILD_ST_SECOND = 3'b100
  } ild_state_t;

  // Number of bytes that an operand of the given size occupies.
  function automatic logic [2:0] ild_size_bytes(input logic [1:0] size);
    logic [2:0] n;
    n = BYTES_IN_WORD;
    if (size == ILD_SIZE_BYTE) begin
      n = BYTES_BYTE;
    end else if (size == ILD_SIZE_HALF) begin
      n = BYTES_HALF;
    end
    return n;
  endfunction

endpackage

/* File: integer_load_address_and_format_tb.sv */
// Self-checking bench for the integer load unit against a data memory model.
`timescale 1ns/1ps
module integer_load_address_and_format_tb;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic clk, rst_n, reqValid, reqReady, reqUpdate, reqString, reqSignExt, reqRejected;
  logic [1:0] reqMode, reqSize;
  logic [4:0] reqBaseField, reqDestField, wbDestField, wbBaseField, bf, df;
  logic [31:0] reqBaseValue, reqIndexValue, memAddr, memRdata, wbDestData, wbBaseData, r;
  logic [15:0] reqDisp, lfsrState;
  logic memReqValid, memAck, wbValid, wbBaseValid, slowMode;
  logic [31:0] accQ[$];
  int nErrors, nTests, cycles;

  ild_load_unit i_dut (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady),
    .reqMode(reqMode), .reqUpdate(reqUpdate), .reqString(reqString), .reqSize(reqSize),
    .reqSignExt(reqSignExt), .reqBaseField(reqBaseField), .reqDestField(reqDestField),
    .reqBaseValue(reqBaseValue), .reqIndexValue(reqIndexValue), .reqDisp(reqDisp),
    .reqRejected(reqRejected), .memReqValid(memReqValid), .memAddr(memAddr),
    .memAck(memAck), .memRdata(memRdata), .wbValid(wbValid), .wbDestField(wbDestField),
    .wbDestData(wbDestData), .wbBaseValid(wbBaseValid), .wbBaseField(wbBaseField),
    .wbBaseData(wbBaseData));

  ild_mem_model i_mem (.clk(clk), .rst_n(rst_n), .slowMode(slowMode),
    .memReqValid(memReqValid), .memAddr(memAddr), .memAck(memAck), .memRdata(memRdata));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Next random value, two steps of the shift register.
  function automatic logic [31:0] rnd();
    logic [15:0] a;
    a = {lfsrState[14:0], lfsrState[15] ^ lfsrState[13] ^ lfsrState[12] ^ lfsrState[10]};
    lfsrState = {a[14:0], a[15] ^ a[13] ^ a[12] ^ a[10]};
    return {a, lfsrState};
  endfunction

  // Word the memory holds at an address.
  function automatic logic [31:0] memWord(input logic [31:0] a);
    return {a[31:2], 2'h0} * 32'h9E37_79B9 ^ 32'hC3A5_5A3C;
  endfunction

  // Operand taken big-endian from two words starting at the address offset, then extended.
  function automatic logic [31:0] expData(input logic [31:0] ea, input logic [1:0] sz,
      input logic sx);
    logic [63:0] p;
    p = {memWord(ea), memWord(ea + 32'h0000_0004)} << (8 * ea[1:0]);
    if (sz == 2'h0) return sx ? {{24{p[63]}}, p[63:56]} : {24'h00_0000, p[63:56]};
    if (sz == 2'h1) return sx ? {{16{p[63]}}, p[63:48]} : {16'h0000, p[63:48]};
    return p[63:32];
  endfunction

  // One comparison, counted, reported at once on a mismatch.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic testDone();
    $display("Comparisons %0d, mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Offers one load, waits for its outcome and compares it with the expected result.
  task automatic doLoad(input logic [1:0] md, input logic up, input logic st,
      input logic [1:0] sz, input logic sx, input logic [4:0] fb, input logic [4:0] fd,
      input logic [31:0] bv, input logic [31:0] iv, input logic [15:0] dp);
    logic [31:0] base, ea;
    logic span, upd;
    int k;
    upd = up && md != 2'h2;
    base = (fb == 5'h00 && !upd) ? 32'h0000_0000 : bv;
    ea = (md == 2'h0) ? base + {{16{dp[15]}}, dp} : (md == 2'h1) ? base + iv : base;
    span = ({1'b0, ea[1:0]} + ((sz == 2'h0) ? 3'h1 : (sz == 2'h1) ? 3'h2 : 3'h4)) > 3'h4;
    @(negedge clk);
    reqMode = md;
    reqUpdate = up;
    reqString = st;
    reqSize = sz;
    reqSignExt = sx;
    reqBaseField = fb;
    reqDestField = fd;
    reqBaseValue = bv;
    reqIndexValue = iv;
    reqDisp = dp;
    reqValid = 1'b1;
    k = 0;
    while (reqReady !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    accQ.delete();
    @(negedge clk);
    reqValid = 1'b0;
    if (md == 2'h3 || (md == 2'h2 && !st)) begin
      check("reqRejected", 32'h0000_0001, 32'(reqRejected));
      check("reqReady", 32'h0000_0001, 32'(reqReady));
      return;
    end
    check("reqRejected", 32'h0000_0000, 32'(reqRejected));
    while (wbValid !== 1'b1 && k < 80) begin
      @(negedge clk);
      k++;
    end
    check("wbValid", 32'h0000_0001, 32'(wbValid));
    check("accesses", span ? 32'h0000_0002 : 32'h0000_0001, 32'(accQ.size()));
    check("memAddr", {ea[31:2], 2'h0}, accQ[0]);
    check("wbDestField", 32'(fd), 32'(wbDestField));
    check("wbDestData", expData(ea, sz, sx), wbDestData);
    check("wbBaseValid", 32'(upd), 32'(wbBaseValid));
    if (upd) begin
      check("wbBaseField", 32'(fb), 32'(wbBaseField));
      check("wbBaseData", ea, wbBaseData);
    end
    @(negedge clk);
    check("wbValid pulse", 32'h0000_0000, 32'(wbValid));
  endtask

  // --------------------------------------------------------------------
  // Clock, memory monitor and hang guard
  // --------------------------------------------------------------------
  // Free-running clock of 8 ns.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Records every memory address that the unit has had answered.
  always @(posedge clk) begin
    if (memReqValid === 1'b1 && memAck === 1'b1) begin
      accQ.push_back(memAddr);
    end
  end

  // Cuts a hang short well above the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      nErrors++;
      testDone();
    end
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  // Resets the unit, runs the corner cases, then a random mix of loads.
  initial begin
    {rst_n, reqValid, reqUpdate, reqString, reqSignExt, reqMode, reqSize} = '0;
    {reqBaseField, reqDestField, reqBaseValue, reqIndexValue, reqDisp, slowMode} = '0;
    lfsrState = 16'h7BF2;
    repeat (12) @(posedge clk);
    check("reqReady in reset", 32'h0000_0001, 32'(reqReady));
    check("memReqValid in reset", 32'h0000_0000, 32'(memReqValid));
    @(negedge clk);
    rst_n = 1'b1;
    doLoad(2'h0, 1'b0, 1'b0, 2'h1, 1'b1, 5'h00, 5'h05, 32'hFFFF_FFFF, 32'h0, 16'h8003);
    doLoad(2'h1, 1'b0, 1'b0, 2'h2, 1'b0, 5'h00, 5'h06, 32'h1234_5678, 32'h0000_1001, 16'h0);
    doLoad(2'h2, 1'b0, 1'b1, 2'h2, 1'b0, 5'h00, 5'h07, 32'hDEAD_BEEF, 32'h0, 16'h0);
    doLoad(2'h2, 1'b1, 1'b1, 2'h0, 1'b0, 5'h09, 5'h07, 32'h0000_0101, 32'h0, 16'h0);
    doLoad(2'h2, 1'b0, 1'b0, 2'h2, 1'b0, 5'h09, 5'h07, 32'h0000_0100, 32'h0, 16'h0);
    doLoad(2'h3, 1'b0, 1'b0, 2'h2, 1'b0, 5'h09, 5'h07, 32'h0000_0100, 32'h0, 16'h0);
    doLoad(2'h0, 1'b1, 1'b0, 2'h0, 1'b1, 5'h00, 5'h04, 32'h0000_2000, 32'h0, 16'h7FFF);
    doLoad(2'h1, 1'b1, 1'b0, 2'h1, 1'b0, 5'h03, 5'h03, 32'h0000_3002, 32'h1, 16'h0);
    for (int i = 0; i < 80; i++) begin
      r = rnd();
      bf = r[12:8];
      df = r[17:13];
      if (r[2] && bf == 5'h00) bf = 5'h01;
      if (r[2] && bf == df) df = bf + 5'h01;
      slowMode = r[18];
      doLoad(r[1:0], r[2], r[3] | r[4], (r[6:5] == 2'h3) ? 2'h2 : r[6:5], r[7], bf, df,
        rnd(), rnd(), r[31:16]);
    end
    testDone();
  end
endmodule
